// ==== csc_pkg.sv ====
// shared constants, types and register map of the color space converter
package csc_pkg;

	// ----------------------------------------------------------------
	// register maps and offsets
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MAP_IO, MAP_CP, MAP_HDMI, MAP_NONE} reg_map_e;

	localparam logic [7:0] IO_SPACE_OFFSET     = 8'h02;
	localparam logic [7:0] HDMI_RANGE_OFFSET   = 8'h47;
	localparam logic [7:0] CP_COEFF_SEL_OFFSET = 8'h68;
	localparam logic [7:0] CP_READBACK_OFFSET  = 8'hf4;

	// field positions
	localparam int INPUT_SPACE_LSB   = 4;
	localparam int SWAP_BIT          = 3;
	localparam int OUTPUT_SEL_BIT    = 1;
	localparam int OVERRIDE_BIT      = 2;
	localparam int MANUAL_FULL_BIT   = 1;
	localparam int COEFF_SEL_LSB     = 4;
	localparam int READBACK_LSB      = 4;

	// reset values
	localparam logic [3:0] INPUT_SPACE_RESET = 4'hf;
	localparam logic [3:0] COEFF_SEL_RESET   = 4'hf;
	localparam logic       OUTPUT_SEL_RESET  = 1'b0;
	localparam logic       SWAP_RESET        = 1'b0;
	localparam logic       OVERRIDE_RESET    = 1'b0;
	localparam logic       MANUAL_FULL_RESET = 1'b0;

	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [3:0] INPUT_SPACE_AUTO = 4'hf;
	localparam logic [3:0] COEFF_SEL_MANUAL = 4'h0;
	localparam logic [3:0] COEFF_SEL_AUTO   = 4'hf;
	localparam logic [3:0] PRIM_HDMI_COMP   = 4'h5;
	localparam logic [3:0] PRIM_HDMI_GRAPH  = 4'h6;

	localparam logic [3:0] MODE_BYPASS   = 4'h0;
	localparam logic [3:0] MODE_601_RGB  = 4'h1;
	localparam logic [3:0] MODE_709_RGB  = 4'h3;
	localparam logic [3:0] MODE_RGB_601  = 4'h5;
	localparam logic [3:0] MODE_RGB_709  = 4'h7;
	localparam logic [3:0] MODE_709_601  = 4'h9;
	localparam logic [3:0] MODE_601_709  = 4'ha;
	localparam logic [3:0] MODE_MANUAL   = 4'hf;

	localparam logic [1:0] SCALE_X1 = 2'h0;
	localparam logic [1:0] SCALE_X2 = 2'h1;
	localparam int         FRAC_BITS = 12;

	// colorimetry class of the incoming video
	typedef enum logic [1:0] {SPACE_RGB, SPACE_601, SPACE_709} space_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	// one channel: three weights and an offset, all 13-bit twos complement
	typedef struct packed {
		logic [12:0] w1;
		logic [12:0] w2;
		logic [12:0] w3;
		logic [12:0] offset;
	} channel_coef_s;

	typedef struct packed {
		logic [1:0]    scale;
		channel_coef_s a;
		channel_coef_s b;
		channel_coef_s c;
	} matrix_s;

	// colorimetry fields of the latest avi infoframe
	typedef struct packed {
		logic       valid;
		logic [1:0] y_format;
		logic [1:0] colorimetry;
		logic [2:0] ext_colorimetry;
		logic [1:0] quant_range;
		logic       it_content;
	} avi_info_s;

endpackage

// ==== color_space_converter.sv ====
// 3x3 color space converter with automatic and manual coefficient selection
`timescale 1ns/10ps
`default_nettype none

module color_space_converter #(
	parameter int COMP_WIDTH = 12
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        reset_i,
	// register port
	input  wire csc_pkg::reg_map_e           reg_map_i,
	input  wire logic [7:0]                  reg_addr_i,
	input  wire logic                        reg_write_i,
	input  wire logic [7:0]                  reg_wdata_i,
	output logic      [7:0]                  reg_rdata_o,
	// mode and upstream status
	input  wire logic [3:0]                  primary_operating_mode_i,
	input  wire csc_pkg::avi_info_s          avi_info_i,
	input  wire csc_pkg::matrix_s            manual_matrix_i,
	// pixel stream in
	input  wire logic                        pixel_valid_i,
	input  wire logic [3*COMP_WIDTH-1:0]     pixel_i,
	// pixel stream out
	output logic                             pixel_valid_o,
	output logic      [3*COMP_WIDTH-1:0]     pixel_o,
	output logic                             input_full_range_o
);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [3:0] input_space_select;
	logic       output_space_select;
	logic       colorimetry_swap;
	logic       rgb_range_override;
	logic       manual_rgb_full_range;
	logic [3:0] coefficient_mode_select;
	logic [3:0] conversion_mode_readback;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			input_space_select      <= csc_pkg::INPUT_SPACE_RESET;
			output_space_select     <= csc_pkg::OUTPUT_SEL_RESET;
			colorimetry_swap        <= csc_pkg::SWAP_RESET;
			rgb_range_override      <= csc_pkg::OVERRIDE_RESET;
			manual_rgb_full_range   <= csc_pkg::MANUAL_FULL_RESET;
			coefficient_mode_select <= csc_pkg::COEFF_SEL_RESET;
		end else if (reg_write_i) begin
			case (reg_map_i)
				csc_pkg::MAP_IO: begin
					if (reg_addr_i == csc_pkg::IO_SPACE_OFFSET) begin
						input_space_select  <= reg_wdata_i[csc_pkg::INPUT_SPACE_LSB +: 4];
						colorimetry_swap    <= reg_wdata_i[csc_pkg::SWAP_BIT];
						output_space_select <= reg_wdata_i[csc_pkg::OUTPUT_SEL_BIT];
					end
				end
				csc_pkg::MAP_HDMI: begin
					if (reg_addr_i == csc_pkg::HDMI_RANGE_OFFSET) begin
						rgb_range_override    <= reg_wdata_i[csc_pkg::OVERRIDE_BIT];
						manual_rgb_full_range <= reg_wdata_i[csc_pkg::MANUAL_FULL_BIT];
					end
				end
				csc_pkg::MAP_CP: begin
					if (reg_addr_i == csc_pkg::CP_COEFF_SEL_OFFSET) begin
						coefficient_mode_select <= reg_wdata_i[csc_pkg::COEFF_SEL_LSB +: 4];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// unmapped addresses and reserved bits read as zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= 8'h00;
			case (reg_map_i)
				csc_pkg::MAP_IO: begin
					if (reg_addr_i == csc_pkg::IO_SPACE_OFFSET) begin
						reg_rdata_o <= {input_space_select, colorimetry_swap, 1'b0,
							output_space_select, 1'b0};
					end
				end
				csc_pkg::MAP_HDMI: begin
					if (reg_addr_i == csc_pkg::HDMI_RANGE_OFFSET) begin
						reg_rdata_o <= {5'h00, rgb_range_override, manual_rgb_full_range, 1'b0};
					end
				end
				csc_pkg::MAP_CP: begin
					if (reg_addr_i == csc_pkg::CP_COEFF_SEL_OFFSET) begin
						reg_rdata_o <= {coefficient_mode_select, 4'h0};
					end else if (reg_addr_i == csc_pkg::CP_READBACK_OFFSET) begin
						reg_rdata_o <= {conversion_mode_readback, 4'h0};
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// infoframe colorimetry tracking
	// ----------------------------------------------------------------
	// last defined colorimetry is held so that a frame without one keeps the space; its range fields still apply
	csc_pkg::space_e hdmi_space;
	logic            hdmi_full_range;
	logic            hdmi_q_zero;
	logic            hdmi_itc;
	logic            hdmi_rgb_full;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hdmi_space      <= csc_pkg::SPACE_RGB;
			hdmi_full_range <= 1'b1;
			hdmi_q_zero     <= 1'b0;
			hdmi_itc        <= 1'b0;
		end else if (avi_info_i.valid) begin
			case (avi_info_i.y_format)
				2'h0: begin
					hdmi_space <= csc_pkg::SPACE_RGB;
					case (avi_info_i.quant_range)
						2'h1: begin
							hdmi_full_range <= 1'b0;
							hdmi_q_zero     <= 1'b0;
						end
						2'h2: begin
							hdmi_full_range <= 1'b1;
							hdmi_q_zero     <= 1'b0;
						end
						// q zero range is resolved live so control writes apply at once
						2'h0: begin
							hdmi_q_zero <= 1'b1;
							hdmi_itc    <= avi_info_i.it_content;
						end
						default: begin
						end
					endcase
				end
				2'h1, 2'h2: begin
					hdmi_full_range <= 1'b1;
					hdmi_q_zero     <= 1'b0;
					case (avi_info_i.colorimetry)
						2'h1: hdmi_space <= csc_pkg::SPACE_601;
						2'h2: hdmi_space <= csc_pkg::SPACE_709;
						2'h3: begin
							if (avi_info_i.ext_colorimetry == 3'h0) begin
								hdmi_space <= csc_pkg::SPACE_601;
							end else if (avi_info_i.ext_colorimetry == 3'h1) begin
								hdmi_space <= csc_pkg::SPACE_709;
							end
						end
						// no colorimetry given, previous one retained
						default: begin
						end
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// input space and mode selection
	// ----------------------------------------------------------------
	// q zero decided by itc unless overridden
	assign hdmi_rgb_full = !hdmi_q_zero ? hdmi_full_range :
		(rgb_range_override ? manual_rgb_full_range : hdmi_itc);

	csc_pkg::space_e next_space;
	logic            next_full_range;
	logic [3:0]      next_mode;
	logic            hdmi_primary;

	// only the hdmi component and graphics modes follow the infoframe
	assign hdmi_primary = (primary_operating_mode_i == csc_pkg::PRIM_HDMI_COMP) ||
		(primary_operating_mode_i == csc_pkg::PRIM_HDMI_GRAPH);

	always_comb begin
		next_space      = csc_pkg::SPACE_RGB;
		next_full_range = 1'b1;
		case (input_space_select)
			4'h0: next_full_range = 1'b0;
			4'h1: next_full_range = 1'b1;
			4'h2: begin
				next_space      = csc_pkg::SPACE_601;
				next_full_range = 1'b0;
			end
			4'h3: begin
				next_space      = csc_pkg::SPACE_709;
				next_full_range = 1'b0;
			end
			4'h4, 4'h6: next_space = csc_pkg::SPACE_601;
			4'h5, 4'h7: next_space = csc_pkg::SPACE_709;
			csc_pkg::INPUT_SPACE_AUTO: begin
				if (hdmi_primary) begin
					next_space      = hdmi_space;
					next_full_range = hdmi_rgb_full;
				end
			end
			// undefined codes fall back to full-range rgb
			default: begin
			end
		endcase
	end

	always_comb begin
		next_mode = csc_pkg::MODE_BYPASS;
		if (coefficient_mode_select == csc_pkg::COEFF_SEL_MANUAL) begin
			next_mode = csc_pkg::MODE_MANUAL;
		end else if (output_space_select) begin
			// output select one always yields rgb
			case (next_space)
				csc_pkg::SPACE_601: next_mode = csc_pkg::MODE_601_RGB;
				csc_pkg::SPACE_709: next_mode = csc_pkg::MODE_709_RGB;
				default:            next_mode = csc_pkg::MODE_BYPASS;
			endcase
		end else begin
			// swap bit toggles 601 and 709
			// ypbpr output chosen from input and swap
			case (next_space)
				csc_pkg::SPACE_RGB:
					next_mode = colorimetry_swap ? csc_pkg::MODE_RGB_709 : csc_pkg::MODE_RGB_601;
				csc_pkg::SPACE_601:
					next_mode = colorimetry_swap ? csc_pkg::MODE_601_709 : csc_pkg::MODE_BYPASS;
				default:
					next_mode = colorimetry_swap ? csc_pkg::MODE_709_601 : csc_pkg::MODE_BYPASS;
			endcase
		end
	end

	// readback follows the selected mode every cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			conversion_mode_readback <= csc_pkg::MODE_BYPASS;
			input_full_range_o       <= 1'b1;
		end else begin
			conversion_mode_readback <= next_mode;
			input_full_range_o       <= next_full_range;
		end
	end

	// ----------------------------------------------------------------
	// coefficient sets
	// ----------------------------------------------------------------
	function automatic csc_pkg::matrix_s fixed_matrix(input logic [3:0] mode);
		csc_pkg::matrix_s m;
		m = '0;
		// fixed coefficient set and scale per auto mode
		case (mode)
			csc_pkg::MODE_601_RGB: m = {csc_pkg::SCALE_X2,
				13'h0800, 13'h1a6a, 13'h1d50, 13'h0423, 13'h0800, 13'h0af8, 13'h0000, 13'h1a84,
				13'h0800, 13'h0000, 13'h0ddb, 13'h1912};
			csc_pkg::MODE_709_RGB: m = {csc_pkg::SCALE_X2,
				13'h0800, 13'h1c54, 13'h1e89, 13'h0291, 13'h0800, 13'h0c52, 13'h0000, 13'h19d7,
				13'h0800, 13'h0000, 13'h0e87, 13'h18bc};
			csc_pkg::MODE_RGB_601: m = {csc_pkg::SCALE_X1,
				13'h0964, 13'h04c9, 13'h01d3, 13'h0000, 13'h1927, 13'h082d, 13'h1eac, 13'h0800,
				13'h1a93, 13'h1d3f, 13'h082d, 13'h0800};
			csc_pkg::MODE_RGB_709: m = {csc_pkg::SCALE_X1,
				13'h0b71, 13'h0368, 13'h0127, 13'h0000, 13'h1893, 13'h082d, 13'h1f3f, 13'h0800,
				13'h19b2, 13'h1e21, 13'h082d, 13'h0800};
			csc_pkg::MODE_709_601: m = {csc_pkg::SCALE_X2,
				13'h0800, 13'h0188, 13'h00cb, 13'h1ed7, 13'h0000, 13'h07de, 13'h1f6c, 13'h005b,
				13'h0000, 13'h1f1d, 13'h07eb, 13'h007b};
			csc_pkg::MODE_601_709: m = {csc_pkg::SCALE_X2,
				13'h0800, 13'h1e56, 13'h1f14, 13'h014a, 13'h0000, 13'h0834, 13'h009a, 13'h1f9a,
				13'h0000, 13'h00eb, 13'h0826, 13'h1f78};
			default: m = '0;
		endcase
		return m;
	endfunction

	csc_pkg::matrix_s active_matrix;
	logic             bypass;

	// manual mode uses the programmed matrix
	assign active_matrix = (conversion_mode_readback == csc_pkg::MODE_MANUAL) ?
		manual_matrix_i : fixed_matrix(conversion_mode_readback);
	assign bypass = (conversion_mode_readback == csc_pkg::MODE_BYPASS);

	// ----------------------------------------------------------------
	// datapath: products summed in stage one, offset and scale in two
	// ----------------------------------------------------------------
	localparam int ACC_WIDTH = COMP_WIDTH + 16;

	csc_pkg::channel_coef_s chan_coef [3];
	logic signed [ACC_WIDTH-1:0] sum_q    [3];
	logic        [12:0]          offset_q [3];
	logic                        scale_x2_q;
	logic                        bypass_q;
	logic                        valid_q;
	logic [3*COMP_WIDTH-1:0]     pixel_q;

	assign chan_coef[0] = active_matrix.a;
	assign chan_coef[1] = active_matrix.b;
	assign chan_coef[2] = active_matrix.c;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			valid_q       <= 1'b0;
			pixel_valid_o <= 1'b0;
			bypass_q      <= 1'b1;
			scale_x2_q    <= 1'b0;
			pixel_q       <= '0;
		end else begin
			valid_q       <= pixel_valid_i;
			pixel_valid_o <= valid_q;
			bypass_q      <= bypass;
			// code 01 doubles, reserved codes treated as one
			scale_x2_q    <= (active_matrix.scale == csc_pkg::SCALE_X2);
			pixel_q       <= pixel_i;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			// component ch of the 36-bit word; a is the top one
			logic signed [COMP_WIDTH:0]  in_a;
			logic signed [COMP_WIDTH:0]  in_b;
			logic signed [COMP_WIDTH:0]  in_c;
			logic signed [ACC_WIDTH-1:0] weighted;
			logic signed [ACC_WIDTH-1:0] total;
			logic signed [ACC_WIDTH-1:0] scaled;
			logic        [COMP_WIDTH-1:0] converted;

			assign in_a = {1'b0, pixel_i[2*COMP_WIDTH +: COMP_WIDTH]};
			assign in_b = {1'b0, pixel_i[COMP_WIDTH +: COMP_WIDTH]};
			assign in_c = {1'b0, pixel_i[0 +: COMP_WIDTH]};

			assign weighted = ACC_WIDTH'(in_a * $signed(chan_coef[ch].w1)) +
				ACC_WIDTH'(in_b * $signed(chan_coef[ch].w2)) +
				ACC_WIDTH'(in_c * $signed(chan_coef[ch].w3));

			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					sum_q[ch]    <= '0;
					offset_q[ch] <= '0;
				end else begin
					sum_q[ch]    <= weighted;
					offset_q[ch] <= chan_coef[ch].offset;
				end
			end

			// divide by 4096 then add offset
			// each channel adds its own offset
			assign total = (sum_q[ch] >>> csc_pkg::FRAC_BITS) +
				ACC_WIDTH'($signed(offset_q[ch]));
			assign scaled = scale_x2_q ? (total <<< 1) : total;
			// clamp instead of wrap so out-of-range settings do not alias
			assign converted = (scaled < 0) ? '0 :
				(scaled > ACC_WIDTH'({COMP_WIDTH{1'b1}})) ? {COMP_WIDTH{1'b1}} :
				scaled[COMP_WIDTH-1:0];

			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					pixel_o[(2-ch)*COMP_WIDTH +: COMP_WIDTH] <= '0;
				end else if (bypass_q) begin
					// bypass uses the same two-stage latency
					pixel_o[(2-ch)*COMP_WIDTH +: COMP_WIDTH] <=
						pixel_q[(2-ch)*COMP_WIDTH +: COMP_WIDTH];
				end else begin
					pixel_o[(2-ch)*COMP_WIDTH +: COMP_WIDTH] <= converted;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ==== csc_sva.sv ====
// port checker for the color space converter
`timescale 1ns/10ps
`default_nettype none

module csc_sva #(
	parameter int COMP_WIDTH = 12
) (
	// clock and reset
	input wire logic                    clk_i,
	input wire logic                    reset_i,
	// register port
	input wire csc_pkg::reg_map_e       reg_map_i,
	input wire logic [7:0]              reg_addr_i,
	input wire logic                    reg_write_i,
	input wire logic [7:0]              reg_wdata_i,
	input wire logic [7:0]              reg_rdata_o,
	// pixel stream
	input wire logic                    pixel_valid_i,
	input wire logic                    pixel_valid_o,
	input wire logic [3*COMP_WIDTH-1:0] pixel_o,
	input wire logic                    input_full_range_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	logic io_at;
	logic rng_at;
	logic sel_at;
	logic rb_at;
	assign io_at  = reg_map_i == csc_pkg::MAP_IO && reg_addr_i == csc_pkg::IO_SPACE_OFFSET;
	assign rng_at = reg_map_i == csc_pkg::MAP_HDMI && reg_addr_i == csc_pkg::HDMI_RANGE_OFFSET;
	assign sel_at = reg_map_i == csc_pkg::MAP_CP && reg_addr_i == csc_pkg::CP_COEFF_SEL_OFFSET;
	assign rb_at  = reg_map_i == csc_pkg::MAP_CP && reg_addr_i == csc_pkg::CP_READBACK_OFFSET;

	chk_valid_delay: assert property (
		!$past(reset_i) && !$past(reset_i, 2) |-> pixel_valid_o == $past(pixel_valid_i, 2))
		else $error("output valid not two cycles after input valid");
	chk_space_write: assert property (
		io_at && reg_write_i ##1 io_at |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hfa))
		else $error("space select byte reads back wrong");
	chk_range_write: assert property (
		rng_at && reg_write_i ##1 rng_at |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h06))
		else $error("range control byte reads back wrong");
	chk_mode_write: assert property (
		sel_at && reg_write_i ##1 sel_at |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hf0))
		else $error("coefficient mode byte reads back wrong");
	chk_readback_ro: assert property (
		rb_at && reg_write_i ##1 rb_at |=> $stable(reg_rdata_o))
		else $error("write changed the mode readback");
	chk_readback_low: assert property (
		!$past(reset_i) && $past(rb_at) |-> reg_rdata_o[3:0] == 4'h0)
		else $error("reserved readback bits not zero");
	chk_forced_full: assert property (
		io_at && reg_write_i && reg_wdata_i[7:4] inside {4'h1, 4'h4, 4'h5, 4'h6, 4'h7}
		|-> ##[1:3] input_full_range_o)
		else $error("forced full range input not reported");
	chk_forced_limited: assert property (
		io_at && reg_write_i && reg_wdata_i[7:4] inside {4'h0, 4'h2, 4'h3} |-> ##[1:3] !input_full_range_o)
		else $error("forced limited range input not reported");

	cover property (pixel_valid_i ##1 pixel_valid_i ##1 pixel_valid_i);
	cover property (sel_at && reg_write_i && reg_wdata_i == 8'h00);
	cover property ($fell(input_full_range_o));
endmodule

bind color_space_converter csc_sva #(.COMP_WIDTH(COMP_WIDTH)) csc_sva_inst (
	.clk_i, .reset_i, .reg_map_i, .reg_addr_i, .reg_write_i, .reg_wdata_i, .reg_rdata_o,
	.pixel_valid_i, .pixel_valid_o, .pixel_o, .input_full_range_o
);
`default_nettype wire

// ==== csc_upstream_model.sv ====
// model of the upstream receive section feeding pixels and infoframe fields
`timescale 1ns/10ps
`default_nettype none

module csc_upstream_model (
	// clock
	input  wire logic          clk_i,
	// toward the converter
	output logic               pixel_valid_o,
	output logic [35:0]        pixel_o,
	output csc_pkg::avi_info_s avi_info_o
);
	initial begin
		pixel_valid_o = 1'b0;
		pixel_o = 36'h0;
		avi_info_o = '0;
	end

	task automatic send_pixel(input logic [35:0] p, input bit last);
		@(posedge clk_i);
		#1;
		pixel_valid_o = 1'b1;
		pixel_o = p;
		if (last) begin
			@(posedge clk_i);
			#1;
			pixel_valid_o = 1'b0;
			// stale word inverted so a converter ignoring valid is caught
			pixel_o = ~p;
		end
	endtask

	task automatic send_info(input logic [1:0] y, c, q, input logic itc);
		@(posedge clk_i);
		#1;
		avi_info_o = '{1'b1, y, c, 3'h0, q, itc};
		@(posedge clk_i);
		#1;
		avi_info_o.valid = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the color space converter
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic               clk_i = 1'b0;
	logic               reset_i = 1'b1;
	csc_pkg::reg_map_e  reg_map_i = csc_pkg::MAP_NONE;
	logic [7:0]         reg_addr_i = 8'h00;
	logic               reg_write_i = 1'b0;
	logic [7:0]         reg_wdata_i = 8'h00;
	logic [3:0]         primary_operating_mode_i = 4'h0;
	csc_pkg::matrix_s   manual_matrix_i = '0;
	logic [7:0]         reg_rdata_o;
	logic               pixel_valid_i;
	logic [35:0]        pixel_i;
	csc_pkg::avi_info_s avi_info_i;
	logic               pixel_valid_o;
	logic [35:0]        pixel_o;
	logic               input_full_range_o;
	int                 bad_count = 0;
	int                 n_tests = 0;
	int                 cycles = 0;
	int                 cls;
	logic [3:0]         em;
	logic [35:0]        exp_q[$];
	logic [3:0]         o0_tab[3][2] = '{'{4'h5, 4'h7}, '{4'h0, 4'ha}, '{4'h0, 4'h9}};
	logic [3:0]         o1_tab[3] = '{4'h0, 4'h1, 4'h3};
	localparam csc_pkg::matrix_s RGB601 = '{2'h0, '{13'h0964, 13'h04c9, 13'h01d3, 13'h0000},
		'{13'h1927, 13'h082d, 13'h1eac, 13'h0800}, '{13'h1a93, 13'h1d3f, 13'h082d, 13'h0800}};
	localparam csc_pkg::matrix_s MAN = '{2'h1, '{13'h0800, 13'h1800, 13'h0000, 13'h0010},
		'{13'h0000, 13'h0000, 13'h0fff, 13'h1fff}, '{13'h0400, 13'h0400, 13'h0400, 13'h0800}};

	csc_upstream_model csc_upstream_model_inst (.clk_i(clk_i), .pixel_valid_o(pixel_valid_i),
		.pixel_o(pixel_i), .avi_info_o(avi_info_i));
	color_space_converter color_space_converter_inst (.clk_i(clk_i), .reset_i(reset_i),
		.reg_map_i(reg_map_i), .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.primary_operating_mode_i(primary_operating_mode_i), .avi_info_i(avi_info_i),
		.manual_matrix_i(manual_matrix_i), .pixel_valid_i(pixel_valid_i), .pixel_i(pixel_i),
		.pixel_valid_o(pixel_valid_o), .pixel_o(pixel_o), .input_full_range_o(input_full_range_o));

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	function automatic logic [11:0] chan(input logic [35:0] p, input csc_pkg::channel_coef_s k,
		input logic [1:0] sc);
		int s;
		s = (int'(p[35:24]) * int'($signed(k.w1)) + int'(p[23:12]) * int'($signed(k.w2))
			+ int'(p[11:0]) * int'($signed(k.w3))) >>> 12;
		s = s + int'($signed(k.offset));
		if (sc == 2'h1) s = s * 2;
		if (s < 0) s = 0;
		if (s > 4095) s = 4095;
		return s[11:0];
	endfunction

	function automatic logic [35:0] conv(input logic [35:0] p, input csc_pkg::matrix_s m);
		return {chan(p, m.a, m.scale), chan(p, m.b, m.scale), chan(p, m.c, m.scale)};
	endfunction

	task automatic check(input string nm, input logic [35:0] e, g);
		n_tests++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	task automatic wr(input csc_pkg::reg_map_e m, input logic [7:0] a, d);
		@(posedge clk_i);
		#1;
		reg_map_i = m;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_write_i = 1'b1;
		@(posedge clk_i);
		#1;
		reg_write_i = 1'b0;
	endtask

	task automatic rd(input csc_pkg::reg_map_e m, input logic [7:0] a, e, input string nm);
		@(posedge clk_i);
		#1;
		reg_map_i = m;
		reg_addr_i = a;
		repeat (3) @(posedge clk_i);
		#1;
		check(nm, 36'(e), 36'(reg_rdata_o));
	endtask

	task automatic px(input logic [35:0] p, e, input bit last);
		exp_q.push_back(e);
		csc_upstream_model_inst.send_pixel(p, last);
	endtask

	task automatic fl(input logic e);
		repeat (3) @(posedge clk_i);
		#1;
		check("full range", 36'(e), 36'(input_full_range_o));
	endtask

	task automatic info(input logic [1:0] y, c, q, input logic itc, e);
		csc_upstream_model_inst.send_info(y, c, q, itc);
		fl(e);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		#2;
		if (pixel_valid_o === 1'b1) begin
			if (exp_q.size() == 0)
				check("extra pixel", 36'h0, 36'h1);
			else
				check("pixel", exp_q.pop_front(), pixel_o);
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		rd(csc_pkg::MAP_IO, 8'h02, 8'hf0, "space byte");
		rd(csc_pkg::MAP_CP, 8'h68, 8'hf0, "mode select");
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h50, "readback");
		rd(csc_pkg::MAP_NONE, 8'h02, 8'h00, "unmapped");
		rd(csc_pkg::MAP_IO, 8'h05, 8'h00, "unmapped");
		for (int code = 0; code < 8; code++) begin
			for (int sw = 0; sw < 2; sw++) begin
				for (int o = 0; o < 2; o++) begin
					cls = (code < 2) ? 0 : (code inside {2, 4, 6}) ? 1 : 2;
					em = o ? o1_tab[cls] : o0_tab[cls][sw];
					wr(csc_pkg::MAP_IO, 8'h02, {4'(code), sw[0], 1'b0, o[0], 1'b0});
					rd(csc_pkg::MAP_CP, 8'hf4, {em, 4'h0}, "readback");
					check("full range", 36'(code inside {1, 4, 5, 6, 7}), 36'(input_full_range_o));
				end
			end
		end
		wr(csc_pkg::MAP_CP, 8'hf4, 8'hff);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h30, "readback");
		wr(csc_pkg::MAP_IO, 8'h02, 8'h10);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h50, "readback");
		px(36'hf_ffff_ffff, conv(36'hf_ffff_ffff, RGB601), 1'b0);
		px(36'h1_2345_6789, conv(36'h1_2345_6789, RGB601), 1'b0);
		px(36'h0, conv(36'h0, RGB601), 1'b1);
		wr(csc_pkg::MAP_IO, 8'h02, 8'h12);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h00, "readback");
		px(36'h1_2345_6789, 36'h1_2345_6789, 1'b1);
		px(36'ha_bcde_f012, 36'ha_bcde_f012, 1'b1);
		manual_matrix_i = MAN;
		wr(csc_pkg::MAP_CP, 8'h68, 8'h00);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'hf0, "readback");
		px(36'hf_ff10_0800, conv(36'hf_ff10_0800, MAN), 1'b0);
		px(36'h0_1002_00ff, conv(36'h0_1002_00ff, MAN), 1'b1);
		manual_matrix_i.scale = 2'h0;
		px(36'hf_ff10_0800, conv(36'hf_ff10_0800, {2'h0, MAN[155:0]}), 1'b1);
		wr(csc_pkg::MAP_CP, 8'h68, 8'hf0);
		wr(csc_pkg::MAP_IO, 8'h02, 8'hf2);
		primary_operating_mode_i = csc_pkg::PRIM_HDMI_COMP;
		info(2'h1, 2'h2, 2'h0, 1'b0, 1'b1);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h30, "readback");
		info(2'h3, 2'h1, 2'h0, 1'b0, 1'b1);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h30, "readback");
		info(2'h1, 2'h1, 2'h0, 1'b0, 1'b1);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h10, "readback");
		primary_operating_mode_i = csc_pkg::PRIM_HDMI_GRAPH;
		info(2'h0, 2'h0, 2'h1, 1'b0, 1'b0);
		rd(csc_pkg::MAP_CP, 8'hf4, 8'h00, "readback");
		info(2'h0, 2'h0, 2'h2, 1'b0, 1'b1);
		info(2'h0, 2'h0, 2'h0, 1'b1, 1'b1);
		info(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		wr(csc_pkg::MAP_HDMI, 8'h47, 8'h06);
		fl(1'b1);
		wr(csc_pkg::MAP_HDMI, 8'h47, 8'h02);
		fl(1'b0);
		wr(csc_pkg::MAP_HDMI, 8'h47, 8'h04);
		info(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
		rd(csc_pkg::MAP_HDMI, 8'h47, 8'h04, "range byte");
		check("pending pixels", 36'h0, 36'(exp_q.size()));
		print_verdict();
	end
endmodule
`default_nettype wire
